// file: hw/leak_monitor_pump_alarm_ctrl.sv
// pump hysteresis, pressure alarm, dry-filter watch and display formatting
// assumes pressure samples arrive from on-chip converter logic on i_clk_sys;
// humidity comparator, temperature switch and key are raw pins
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

module leak_monitor_pump_alarm_ctrl #(
  parameter int RUN_MIN_CYCLES = leak_monitor_pkg::PUMP_RUN_MIN_CYCLES,
  parameter int DEBOUNCE_CYCLES = leak_monitor_pkg::DEBOUNCE_CYCLES,
  parameter int LONG_PRESS_CYCLES = leak_monitor_pkg::LONG_PRESS_CYCLES,
  parameter int FLASH_HALF_CYCLES = leak_monitor_pkg::FLASH_HALF_CYCLES,
  parameter int CONFIRM_CYCLES = leak_monitor_pkg::CONFIRM_CYCLES
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_irq,
  // sensors and key
  input wire logic [15:0] i_pressure,
  input wire logic i_pressure_valid,
  input wire logic i_humid_high,
  input wire logic i_temp_low,
  input wire logic i_ack_key,
  // actuators and indicators
  output logic o_pump,
  output logic o_buzzer,
  output leak_monitor_pkg::lamps_type o_lamps,
  output logic o_relay_nc_closed,
  output logic o_relay_no_closed,
  output leak_monitor_pkg::display_type o_display
);

  function automatic logic [15:0] hysteresis(input logic [15:0] level);
    hysteresis = (level >= leak_monitor_pkg::HYST_LEVEL_MBAR) ?
                 leak_monitor_pkg::HYST_HIGH_MBAR : leak_monitor_pkg::HYST_LOW_MBAR;
  endfunction

  function automatic logic hit(input logic [31:0] cnt, input int limit);
    hit = (cnt >= 32'(limit - 1));
  endfunction

  // software state
  logic [1:0] ctrl;
  logic [15:0] alarm_on_threshold;
  logic [15:0] refill_off_threshold;
  logic [leak_monitor_pkg::INT_W-1:0] int_status;
  logic [leak_monitor_pkg::INT_W-1:0] int_mask;
  logic [15:0] pressure;

  // control state
  logic pump_on;
  logic alarm_on;
  logic dry_active;
  logic dry_muted;
  logic evaluated;
  logic [31:0] run_cnt;

  // pin synchronisers, first stage read only by second
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  wire logic [2:0] raw_pins = {i_ack_key, i_temp_low, i_humid_high};
  wire logic humid_s = sync_b[0];
  wire logic cold_s = sync_b[1];
  wire logic key_s = sync_b[2];

  // key
  logic key_stable;
  logic [31:0] bounce_cnt;
  logic [31:0] hold_cnt;
  logic long_fired;
  logic short_evt;
  logic long_evt;

  // indication timing
  logic [31:0] flash_cnt;
  logic flash;
  logic [31:0] confirm_cnt;

  logic [15:0] alarm_off_threshold;
  logic [15:0] refill_on_threshold;
  logic filter_opt;
  logic unit_psi;
  logic high_rating;
  logic dry_raise;
  logic [leak_monitor_pkg::INT_W-1:0] events;
  logic [leak_monitor_pkg::INT_W-1:0] next_int_status;
  leak_monitor_pkg::display_type next_display;

  assign filter_opt = ctrl[leak_monitor_pkg::CTRL_FILTER_OPT];
  assign unit_psi = ctrl[leak_monitor_pkg::CTRL_UNIT_PSI];
  assign alarm_off_threshold = alarm_on_threshold + hysteresis(alarm_on_threshold);
  assign refill_on_threshold = refill_off_threshold - hysteresis(refill_off_threshold);
  assign high_rating = (alarm_on_threshold > leak_monitor_pkg::HIGH_RATING_MBAR);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= raw_pins[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  // register writes
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl <= leak_monitor_pkg::CTRL_RST;
      alarm_on_threshold <= leak_monitor_pkg::ALARM_ON_RST;
      refill_off_threshold <= leak_monitor_pkg::REFILL_OFF_RST;
      int_mask <= leak_monitor_pkg::INT_MASK_RST;
    end else if (i_wr) begin
      case (i_addr)
        leak_monitor_pkg::ADDR_CTRL: ctrl <= i_wdata[1:0];
        leak_monitor_pkg::ADDR_ALARM_ON: alarm_on_threshold <= i_wdata;
        leak_monitor_pkg::ADDR_REFILL_OFF: refill_off_threshold <= i_wdata;
        leak_monitor_pkg::ADDR_INT_MASK: int_mask <= i_wdata[leak_monitor_pkg::INT_W-1:0];
        default: ;
      endcase
    end
  end

  // register reads, data in the following cycle only
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        leak_monitor_pkg::ADDR_CTRL: o_rdata <= {14'h0000, ctrl};
        leak_monitor_pkg::ADDR_ALARM_ON: o_rdata <= alarm_on_threshold;
        leak_monitor_pkg::ADDR_REFILL_OFF: o_rdata <= refill_off_threshold;
        leak_monitor_pkg::ADDR_STATE: begin
          o_rdata <= {9'h000, key_stable, cold_s, humid_s, dry_muted, dry_active,
                      alarm_on, pump_on};
        end
        leak_monitor_pkg::ADDR_INT_STATUS: o_rdata <= {9'h000, int_status};
        leak_monitor_pkg::ADDR_INT_MASK: o_rdata <= {9'h000, int_mask};
        leak_monitor_pkg::ADDR_PRESSURE: o_rdata <= pressure;
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // pump and alarm decided on each sample
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pressure <= 16'h0000;
      pump_on <= 1'b0;
      alarm_on <= 1'b0;
    end else if (i_pressure_valid) begin
      pressure <= i_pressure;
      if (i_pressure >= refill_off_threshold) begin
        pump_on <= 1'b0;
      end else if (i_pressure <= refill_on_threshold) begin
        pump_on <= 1'b1;
      end
      if (i_pressure <= alarm_on_threshold) begin
        alarm_on <= 1'b1;
      end else if (i_pressure > alarm_off_threshold) begin
        alarm_on <= 1'b0;
      end
    end
  end

  // key debounce
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      key_stable <= 1'b0;
      bounce_cnt <= 32'h0000_0000;
    end else if (key_s == key_stable) begin
      bounce_cnt <= 32'h0000_0000;
    end else if (hit(bounce_cnt, DEBOUNCE_CYCLES)) begin
      key_stable <= key_s;
      bounce_cnt <= 32'h0000_0000;
    end else begin
      bounce_cnt <= bounce_cnt + 32'h0000_0001;
    end
  end

  // press classification: long fires while held, brief on release
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      hold_cnt <= 32'h0000_0000;
      long_fired <= 1'b0;
      short_evt <= 1'b0;
      long_evt <= 1'b0;
    end else begin
      short_evt <= 1'b0;
      long_evt <= 1'b0;
      if (key_stable) begin
        if (!long_fired) begin
          if (hit(hold_cnt, LONG_PRESS_CYCLES)) begin
            long_fired <= 1'b1;
            long_evt <= 1'b1;
          end else begin
            hold_cnt <= hold_cnt + 32'h0000_0001;
          end
        end
      end else begin
        hold_cnt <= 32'h0000_0000;
        long_fired <= 1'b0;
        short_evt <= (hold_cnt != 32'h0000_0000) && !long_fired;
      end
    end
  end

  // continuous run timer; a fresh start or a full acknowledge restarts it
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      run_cnt <= 32'h0000_0000;
      evaluated <= 1'b0;
    end else if (!pump_on || long_evt) begin
      run_cnt <= 32'h0000_0000;
      evaluated <= 1'b0;
    end else if (!evaluated) begin
      if (hit(run_cnt, RUN_MIN_CYCLES)) begin
        evaluated <= 1'b1;
      end else begin
        run_cnt <= run_cnt + 32'h0000_0001;
      end
    end
  end

  // cold air gives no usable reading, so that run is skipped
  assign dry_raise = pump_on && !evaluated && !long_evt && hit(run_cnt, RUN_MIN_CYCLES) &&
                     filter_opt && !cold_s && humid_s;

  // dry-filter signal; a clear wins over a raise in the same cycle, as dry_raise is gated by long_evt
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      dry_active <= 1'b0;
      dry_muted <= 1'b0;
    end else if (dry_raise) begin
      dry_active <= 1'b1;
      dry_muted <= 1'b0;
    end else if (long_evt) begin
      dry_active <= 1'b0;
      dry_muted <= 1'b0;
    end else if (short_evt && dry_active) begin
      dry_muted <= 1'b1;
    end
  end

  // flash clock and long-press confirmation
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      flash_cnt <= 32'h0000_0000;
      flash <= 1'b0;
    end else if (hit(flash_cnt, FLASH_HALF_CYCLES)) begin
      flash_cnt <= 32'h0000_0000;
      flash <= !flash;
    end else begin
      flash_cnt <= flash_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      confirm_cnt <= 32'h0000_0000;
    end else if (long_evt) begin
      confirm_cnt <= 32'(CONFIRM_CYCLES);
    end else if (confirm_cnt != 32'h0000_0000) begin
      confirm_cnt <= confirm_cnt - 32'h0000_0001;
    end
  end

  // outputs; a steady pressure alarm overrides the dry-filter flashing on red
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_pump <= 1'b0;
      o_buzzer <= 1'b0;
      o_lamps <= '0;
      o_relay_nc_closed <= 1'b1;
      o_relay_no_closed <= 1'b0;
    end else begin
      o_pump <= pump_on;
      o_buzzer <= alarm_on || (dry_active && !dry_muted) || (confirm_cnt != 32'h0000_0000);
      o_lamps.red_a <= alarm_on || (dry_active && flash);
      o_lamps.red_b <= alarm_on || (dry_active && !flash && !high_rating);
      o_lamps.yellow <= dry_active && !flash && high_rating;
      o_lamps.bottom <= (confirm_cnt != 32'h0000_0000) && flash;
      o_relay_nc_closed <= !dry_active;
      o_relay_no_closed <= dry_active;
    end
  end

  // display formatting
  always_comb begin
    logic [31:0] mbar;
    logic [31:0] psi100;
    mbar = {16'h0000, pressure};
    psi100 = (mbar * leak_monitor_pkg::PSI100_MUL) >> leak_monitor_pkg::PSI100_SHIFT;
    next_display = '0;
    next_display.unit_psi = unit_psi;
    next_display.unit_bar = !unit_psi && (pressure >= leak_monitor_pkg::BAR_MBAR);
    if (unit_psi) begin
      next_display.blank = high_rating && (psi100 < leak_monitor_pkg::DISP_MIN_PSI100);
      if (psi100 < leak_monitor_pkg::PSI_TWO_DEC_LIMIT) begin
        next_display.value = psi100[15:0];
        next_display.decimals = leak_monitor_pkg::DEC_TWO;
      end else begin
        next_display.value = 16'(psi100 / 32'h0000_000a);
        next_display.decimals = leak_monitor_pkg::DEC_ONE;
      end
    end else begin
      next_display.blank = high_rating && (pressure < leak_monitor_pkg::DISP_MIN_MBAR);
      if (pressure < leak_monitor_pkg::BAR_MBAR) begin
        next_display.value = pressure;
        next_display.decimals = leak_monitor_pkg::DEC_NONE;
      end else if (pressure < leak_monitor_pkg::TEN_BAR_MBAR) begin
        next_display.value = 16'(mbar / 32'h0000_000a);
        next_display.decimals = leak_monitor_pkg::DEC_TWO;
      end else begin
        next_display.value = 16'(mbar / 32'h0000_0064);
        next_display.decimals = leak_monitor_pkg::DEC_ONE;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_display <= '0;
    end else begin
      o_display <= next_display;
    end
  end

  // interrupts: pump and alarm events are edges against the previous values of pump_on and alarm_on; dry and key events pass straight through
  logic pump_q;
  logic alarm_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pump_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      pump_q <= pump_on;
      alarm_q <= alarm_on;
    end
  end

  always_comb begin
    events = '0;
    events[leak_monitor_pkg::EV_ALARM_SET] = alarm_on && !alarm_q;
    events[leak_monitor_pkg::EV_ALARM_CLR] = !alarm_on && alarm_q;
    events[leak_monitor_pkg::EV_PUMP_ON] = pump_on && !pump_q;
    events[leak_monitor_pkg::EV_PUMP_OFF] = !pump_on && pump_q;
    events[leak_monitor_pkg::EV_DRY_SET] = dry_raise;
    events[leak_monitor_pkg::EV_SHORT_KEY] = short_evt;
    events[leak_monitor_pkg::EV_LONG_KEY] = long_evt;
    next_int_status = int_status;
    if (i_rd && (i_addr == leak_monitor_pkg::ADDR_INT_STATUS)) begin
      next_int_status = '0;
    end
    next_int_status = next_int_status | events;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      int_status <= '0;
      o_irq <= 1'b0;
    end else begin
      int_status <= next_int_status;
      o_irq <= |(next_int_status & int_mask);
    end
  end

endmodule

// file: hw/leak_monitor_pkg.sv
// constants, register map and carrier types for the leak monitor controller
// assumes a 10 MHz system clock and pressure samples in whole millibar
package leak_monitor_pkg;

  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int PUMP_RUN_MIN_S = 30;
  localparam int PUMP_RUN_MIN_CYCLES = PUMP_RUN_MIN_S * CLK_HZ;
  localparam int DEBOUNCE_MS = 20;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CYCLES_PER_MS;
  localparam int LONG_PRESS_MS = 3000;
  localparam int LONG_PRESS_CYCLES = LONG_PRESS_MS * CYCLES_PER_MS;
  localparam int FLASH_HALF_MS = 500;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * CYCLES_PER_MS;
  localparam int CONFIRM_MS = 3000;
  localparam int CONFIRM_CYCLES = CONFIRM_MS * CYCLES_PER_MS;

  // pressure figures, mbar
  localparam logic [15:0] HYST_LOW_MBAR = 16'h000f;
  localparam logic [15:0] HYST_HIGH_MBAR = 16'h0064;
  localparam logic [15:0] HYST_LEVEL_MBAR = 16'h03e8;
  localparam logic [15:0] HIGH_RATING_MBAR = 16'h024e;
  localparam logic [15:0] DISP_MIN_MBAR = 16'h0032;
  localparam logic [15:0] BAR_MBAR = 16'h03e8;
  localparam logic [15:0] TEN_BAR_MBAR = 16'h2710;
  // psi x100 = mbar * 1485 / 1024
  localparam logic [31:0] PSI100_MUL = 32'h0000_05cd;
  localparam int PSI100_SHIFT = 10;
  localparam logic [31:0] DISP_MIN_PSI100 = 32'h0000_0049;
  localparam logic [31:0] PSI_TWO_DEC_LIMIT = 32'h0000_2710;

  // register map, word index on a 4-bit address
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ALARM_ON = 4'h1;
  localparam logic [3:0] ADDR_REFILL_OFF = 4'h2;
  localparam logic [3:0] ADDR_STATE = 4'h3;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h4;
  localparam logic [3:0] ADDR_INT_MASK = 4'h5;
  localparam logic [3:0] ADDR_PRESSURE = 4'h6;

  // control fields
  localparam int CTRL_FILTER_OPT = 0;
  localparam int CTRL_UNIT_PSI = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] ALARM_ON_RST = 16'h0000;
  localparam logic [15:0] REFILL_OFF_RST = 16'h0000;

  // interrupt event bits
  localparam int INT_W = 7;
  localparam int EV_ALARM_SET = 0;
  localparam int EV_ALARM_CLR = 1;
  localparam int EV_PUMP_ON = 2;
  localparam int EV_PUMP_OFF = 3;
  localparam int EV_DRY_SET = 4;
  localparam int EV_SHORT_KEY = 5;
  localparam int EV_LONG_KEY = 6;
  localparam logic [INT_W-1:0] INT_MASK_RST = 7'h00;

  // display decimals
  localparam logic [1:0] DEC_NONE = 2'h0;
  localparam logic [1:0] DEC_ONE = 2'h1;
  localparam logic [1:0] DEC_TWO = 2'h2;

  typedef struct packed {
    logic [15:0] value;
    logic [1:0] decimals;
    logic blank;
    logic unit_psi;
    logic unit_bar;
  } display_type;

  typedef struct packed {
    logic red_a;
    logic red_b;
    logic yellow;
    logic bottom;
  } lamps_type;

endpackage

// file: sim/leak_monitor_pump_alarm_ctrl_sva.sv
// checker for pump, alarm, dry-filter and display outputs
// sees top-level ports only; thresholds are copied from register writes
`timescale 1ns/100ps
module leak_monitor_pump_alarm_ctrl_sva #(
  parameter int RUN_MIN_CYCLES = 50
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // register port and sensors
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic [15:0] i_pressure,
  input wire logic i_pressure_valid,
  // outputs watched
  input wire logic o_pump,
  input wire logic o_buzzer,
  input wire leak_monitor_pkg::lamps_type o_lamps,
  input wire logic o_relay_nc_closed,
  input wire logic o_relay_no_closed,
  input wire leak_monitor_pkg::display_type o_display
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic [15:0] refill;
  logic [15:0] alarm;
  logic [1:0] ctrl;
  logic [10:0] run_cnt;
  logic [15:0] hr;
  logic [15:0] ha;
  logic pv;
  assign hr = (refill >= leak_monitor_pkg::HYST_LEVEL_MBAR) ? 16'h0064 : 16'h000f;
  assign ha = (alarm >= leak_monitor_pkg::HYST_LEVEL_MBAR) ? 16'h0064 : 16'h000f;
  assign pv = i_pressure_valid;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      refill <= 16'h0000;
      alarm <= 16'h0000;
      ctrl <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == leak_monitor_pkg::ADDR_REFILL_OFF) refill <= i_wdata;
      if (i_addr == leak_monitor_pkg::ADDR_ALARM_ON) alarm <= i_wdata;
      if (i_addr == leak_monitor_pkg::ADDR_CTRL) ctrl <= i_wdata[1:0];
    end
  end
  // saturates so a long run never wraps back under the minimum
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !o_pump) run_cnt <= 11'h000;
    else if (run_cnt != 11'h7ff) run_cnt <= run_cnt + 11'h001;
  end
  property p_pump_off;
    pv && i_pressure >= refill |-> ##2 !o_pump;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump still on");
  property p_pump_on;
    pv && refill >= hr && i_pressure <= refill - hr |-> ##2 o_pump;
  endproperty
  a_pump_on: assert property (p_pump_on) else $error("pump not on");
  property p_alarm_on;
    pv && i_pressure <= alarm |-> ##2 (o_buzzer && o_lamps.red_a && o_lamps.red_b);
  endproperty
  a_alarm_on: assert property (p_alarm_on) else $error("alarm missing");
  property p_alarm_off;
    pv && i_pressure > alarm + ha |-> ##2 !(o_lamps.red_a && o_lamps.red_b);
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm not cleared");
  property p_relay_pair;
    o_relay_nc_closed != o_relay_no_closed;
  endproperty
  a_relay_pair: assert property (p_relay_pair) else $error("relay contacts agree");
  property p_dry_run;
    $rose(o_relay_no_closed) |-> ctrl[0] && int'(run_cnt) >= RUN_MIN_CYCLES - 4;
  endproperty
  a_dry_run: assert property (p_dry_run) else $error("dry raised without run");
  property p_long_clear;
    $fell(o_relay_no_closed) |-> ##[0:1] o_buzzer;
  endproperty
  a_long_clear: assert property (p_long_clear) else $error("no confirm tone");
  property p_disp_mbar;
    (pv && i_pressure >= 16'h0032 && i_pressure < 16'h03e8) ##1 !ctrl[1] |-> ##1
      (o_display.value == $past(i_pressure, 2) && o_display.decimals == 2'h0
      && !o_display.blank);
  endproperty
  a_disp_mbar: assert property (p_disp_mbar) else $error("mbar display wrong");
  property p_disp_blank;
    (pv && i_pressure < 16'h0032) ##1 (!ctrl[1] && alarm > 16'h024e) |-> ##1 o_display.blank;
  endproperty
  a_disp_blank: assert property (p_disp_blank) else $error("small value shown");
  c_dry: cover property ($rose(o_relay_no_closed));
  c_clear: cover property ($fell(o_relay_no_closed));
  c_alarm: cover property (o_lamps.red_a && o_lamps.red_b);
endmodule
bind leak_monitor_pump_alarm_ctrl leak_monitor_pump_alarm_ctrl_sva #(
  .RUN_MIN_CYCLES(RUN_MIN_CYCLES)
) chk_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_pressure(i_pressure), .i_pressure_valid(i_pressure_valid),
  .o_pump(o_pump), .o_buzzer(o_buzzer), .o_lamps(o_lamps),
  .o_relay_nc_closed(o_relay_nc_closed), .o_relay_no_closed(o_relay_no_closed),
  .o_display(o_display));

// file: sim/leak_sensor_model.sv
// sensor front end: pressure converter strobe, humidity and frost pins
// assumes the bench sets level and pin states; one clock
`timescale 1ns/100ps
module leak_sensor_model (
  // clock and bench settings
  input wire logic i_clk_sys,
  input wire logic [15:0] i_level,
  input wire logic i_humid,
  input wire logic i_cold,
  // pins towards the controller
  output logic [15:0] o_pressure,
  output logic o_valid,
  output logic o_humid_high,
  output logic o_temp_low
);
  logic phase = 1'b0;
  initial o_valid = 1'b0;
  initial o_pressure = 16'h0000;
  // strobe every second cycle; bus shows garbage outside the strobe
  always @(posedge i_clk_sys) begin
    phase <= !phase;
    o_valid <= phase;
    o_pressure <= phase ? i_level : ~i_level;
  end
  assign o_humid_high = i_humid;
  assign o_temp_low = i_cold;
endmodule

// file: sim/leak_monitor_pump_alarm_ctrl_tb.sv
// self-checking bench for the leak monitor pump and alarm controller
// assumes the sensor model feeds pressure and pins; short counts
`timescale 1ns/100ps
module leak_monitor_pump_alarm_ctrl_tb;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic key = 1'b0;
  logic humid = 1'b0;
  logic cold = 1'b0;
  logic [15:0] level = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] pressure;
  logic pvalid, humid_pin, cold_pin, pump, buzzer, irq, nc, no;
  leak_monitor_pkg::lamps_type lamps;
  leak_monitor_pkg::display_type disp;
  int miscompares = 0;
  int tests_run = 0;
  initial forever #50 i_clk_sys = ~i_clk_sys;
  leak_sensor_model sensor_u (.i_clk_sys(i_clk_sys), .i_level(level), .i_humid(humid),
    .i_cold(cold), .o_pressure(pressure), .o_valid(pvalid), .o_humid_high(humid_pin),
    .o_temp_low(cold_pin));
  leak_monitor_pump_alarm_ctrl #(.RUN_MIN_CYCLES(50), .DEBOUNCE_CYCLES(3),
    .LONG_PRESS_CYCLES(20), .FLASH_HALF_CYCLES(4), .CONFIRM_CYCLES(10)) dut_u (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_pressure(pressure),
    .i_pressure_valid(pvalid), .i_humid_high(humid_pin), .i_temp_low(cold_pin),
    .i_ack_key(key), .o_pump(pump), .o_buzzer(buzzer), .o_lamps(lamps),
    .o_relay_nc_closed(nc), .o_relay_no_closed(no), .o_display(disp));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    @(negedge i_clk_sys);
    chk(n, rdata, e);
  endtask
  task automatic setp(input logic [15:0] p);
    @(posedge i_clk_sys);
    level <= p;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  task automatic press(input int n);
    @(posedge i_clk_sys);
    key <= 1'b1;
    repeat (n) @(posedge i_clk_sys);
    key <= 1'b0;
    repeat (12) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  task automatic dsp(input logic [15:0] c, input logic [15:0] p, input logic [15:0] v,
    input logic [1:0] d, input logic b);
    wr_reg(leak_monitor_pkg::ADDR_CTRL, c);
    setp(p);
    chk("blank", {15'h0, disp.blank}, {15'h0, b});
    chk("unit", {14'h0, disp.unit_psi, disp.unit_bar}, {14'h0, c[1], !c[1] && p >= leak_monitor_pkg::BAR_MBAR});
    if (!b) begin
      chk("value", disp.value, v);
      chk("decimals", {14'h0, disp.decimals}, {14'h0, d});
    end
  endtask
  task automatic t_reset;
    rd_reg("ctrl", leak_monitor_pkg::ADDR_CTRL, 16'h0000);
    rd_reg("alarm on", leak_monitor_pkg::ADDR_ALARM_ON, 16'h0000);
    rd_reg("refill off", leak_monitor_pkg::ADDR_REFILL_OFF, 16'h0000);
    rd_reg("mask", leak_monitor_pkg::ADDR_INT_MASK, 16'h0000);
    wr_reg(4'h7, 16'hffff);
    rd_reg("unmapped", 4'h7, 16'h0000);
    chk("nc rest", {15'h0, nc}, 16'h0001);
    $display("reset test done");
  endtask
  task automatic t_pump;
    wr_reg(leak_monitor_pkg::ADDR_REFILL_OFF, 16'd300);
    wr_reg(leak_monitor_pkg::ADDR_ALARM_ON, 16'd200);
    setp(16'd300);
    chk("pump top", {15'h0, pump}, 16'h0000);
    setp(16'd290);
    chk("pump 290", {15'h0, pump}, 16'h0000);
    chk("disp 290", disp.value, 16'd290);
    setp(16'd285);
    chk("pump 285", {15'h0, pump}, 16'h0001);
    setp(16'd299);
    chk("pump 299", {15'h0, pump}, 16'h0001);
    setp(16'd300);
    chk("pump 300", {15'h0, pump}, 16'h0000);
    rd_reg("sample", leak_monitor_pkg::ADDR_PRESSURE, 16'h012c);
    $display("pump test done");
  endtask
  task automatic t_alarm;
    wr_reg(leak_monitor_pkg::ADDR_INT_MASK, 16'h0001);
    @(posedge i_clk_sys);
    rd <= 1'b1;
    addr <= leak_monitor_pkg::ADDR_INT_STATUS;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    setp(16'd200);
    chk("alarm buzzer", {15'h0, buzzer}, 16'h0001);
    chk("alarm lamps", {14'h0, lamps.red_a, lamps.red_b}, 16'h0003);
    chk("irq set", {15'h0, irq}, 16'h0001);
    rd_reg("status", leak_monitor_pkg::ADDR_INT_STATUS, 16'h0005);
    chk("irq clear", {15'h0, irq}, 16'h0000);
    setp(16'd215);
    chk("alarm hold", {15'h0, buzzer}, 16'h0001);
    setp(16'd216);
    chk("alarm off", {15'h0, buzzer}, 16'h0000);
    $display("alarm test done");
  endtask
  task automatic t_dry;
    logic seen;
    wr_reg(leak_monitor_pkg::ADDR_CTRL, 16'h0001);
    humid <= 1'b1;
    setp(16'd300);
    setp(16'd250);
    repeat (70) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk("dry no", {15'h0, no}, 16'h0001);
    chk("dry nc", {15'h0, nc}, 16'h0000);
    chk("dry tone", {15'h0, buzzer}, 16'h0001);
    chk("flash", {14'h0, lamps.yellow, lamps.red_a ^ lamps.red_b}, 16'h0001);
    rd_reg("state", leak_monitor_pkg::ADDR_STATE, 16'h0015);
    press(10);
    chk("muted", {15'h0, buzzer}, 16'h0000);
    chk("still no", {15'h0, no}, 16'h0001);
    @(posedge i_clk_sys);
    key <= 1'b1;
    seen = 1'b0;
    repeat (40) begin
      @(negedge i_clk_sys);
      seen = seen | lamps.bottom;
    end
    @(posedge i_clk_sys);
    key <= 1'b0;
    chk("cleared", {15'h0, no}, 16'h0000);
    chk("bottom", {15'h0, seen}, 16'h0001);
    repeat (60) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk("recheck", {15'h0, no}, 16'h0001);
    $display("dry test done");
  endtask
  task automatic t_gate;
    setp(16'd300);
    press(30);
    chk("off clr", {15'h0, no}, 16'h0000);
    @(posedge i_clk_sys);
    cold <= 1'b1;
    setp(16'd250);
    repeat (70) @(posedge i_clk_sys);
    chk("cold", {15'h0, no}, 16'h0000);
    cold <= 1'b0;
    setp(16'd300);
    setp(16'd250);
    repeat (20) @(posedge i_clk_sys);
    setp(16'd300);
    repeat (50) @(posedge i_clk_sys);
    chk("short run", {15'h0, no}, 16'h0000);
    $display("gate test done");
  endtask
  task automatic t_disp;
    wr_reg(leak_monitor_pkg::ADDR_ALARM_ON, 16'd600);
    dsp(16'h0000, 16'd1234, 16'd123, leak_monitor_pkg::DEC_TWO, 1'b0);
    dsp(16'h0000, 16'd12345, 16'd123, leak_monitor_pkg::DEC_ONE, 1'b0);
    dsp(16'h0000, 16'd40, 16'd0, leak_monitor_pkg::DEC_NONE, 1'b1);
    dsp(16'h0000, 16'd50, 16'd50, leak_monitor_pkg::DEC_NONE, 1'b0);
    dsp(16'h0002, 16'd100, 16'd145, leak_monitor_pkg::DEC_TWO, 1'b0);
    dsp(16'h0002, 16'd10000, 16'd1450, leak_monitor_pkg::DEC_ONE, 1'b0);
    dsp(16'h0002, 16'd50, 16'd0, leak_monitor_pkg::DEC_NONE, 1'b1);
    $display("display test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_reset;
    t_pump;
    t_alarm;
    t_dry;
    t_gate;
    t_disp;
    print_verdict;
  end
  // whole run is near 600 cycles
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    miscompares++;
    print_verdict;
  end
endmodule
